// ===== spu_pkg.sv
// Constants, register map and state encodings of the serial port
// How it works
// R01 - Mode 00: synchronous shift, clock on transmit pin
// R02 - Mode 01: start, eight data, stop
// R03 - Mode 10: eleven bits with ninth bit
// R04 - Mode 11: eleven bits, timer-driven rate
// R05 - Address filter only counts in eleven-bit modes
// R06 - Filter off: every frame sets receive flag
// R07 - Filter on: flag only when ninth bit set
// R08 - Receive enable gates all reception
// R09 - Control bit 2 holds received ninth bit
// R10 - Control bit 1 is transmit done flag
// R11 - Control bit 0 is receive done flag
// R12 - Control bit 3 supplies transmitted ninth bit
// R13 - Flags set by hardware, cleared writing zero
// R14 - Buffer write starts send, read returns latch
// R15 - Shift rate twelfth or quarter of clock
// R16 - Fixed mode rate sixty-fourth or thirty-second
// R17 - Timer overflow rate, per-direction timer select
package spu_pkg;
  localparam logic [11:0] CTRL_INDEX = 12'h098;
  localparam logic [11:0] BUF_INDEX = 12'h099;
  localparam logic [11:0] ADDR_CTRL = 12'h260;
  localparam logic [11:0] ADDR_BUF = 12'h264;
  localparam logic [11:0] ADDR_RATE = 12'h300;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h304;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h308;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_MP_FILTER = 5;
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;
  localparam int BIT_RATE_DOUBLER = 0;
  localparam int BIT_TX_TIMER_B = 1;
  localparam int BIT_RX_TIMER_B = 2;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam logic [2:0] RATE_RESET = 3'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int SHIFT_DIV_SLOW = 12;
  localparam int SHIFT_DIV_FAST = 4;
  localparam int FIX_DIV_SLOW = 64;
  localparam int FIX_DIV_FAST = 32;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SUB_SLOW = 4'(FIX_DIV_SLOW / OVERSAMPLE);
  localparam logic [3:0] SUB_FAST = 4'(FIX_DIV_FAST / OVERSAMPLE);
  localparam logic [3:0] M0_SLOW = 4'(SHIFT_DIV_SLOW);
  localparam logic [3:0] M0_FAST = 4'(SHIFT_DIV_FAST);
  localparam logic [3:0] SUB_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] SUB_MID = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0] BITS_TEN = 4'h a;
  localparam logic [3:0] BITS_ELEVEN = 4'h b;
  localparam logic [3:0] BITS_SHIFT = 4'h8;
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_TEN = 2'b01,
    MODE_FIX = 2'b10,
    MODE_VAR = 2'b11
  } spu_mode_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ASYNC = 2'b01,
    TX_SYNC = 2'b10
  } spu_tx_state_t;
  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_BUSY = 1'b1
  } spu_rx_state_t;
endpackage

// ===== spu_serial_port.sv
// Serial port with APB register access
`timescale 1ns/10ps
module spu_serial_port
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_a_ovf,
  input wire logic timer_b_ovf,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  output logic irq
);
  import spu_pkg::*;

  logic [7:0] serial_control;
  logic [7:0] rx_latch;
  logic [2:0] rate_config;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic rxd_meta;
  logic rxd_sync;
  logic rxd_prev;
  logic ta_phase;
  logic [3:0] fix_cnt;
  logic fix_tick;
  spu_tx_state_t tx_state;
  spu_rx_state_t rx_state;
  logic [10:0] tx_shift;
  logic [3:0] tx_sub;
  logic [3:0] tx_bits;
  logic [3:0] m0_cnt;
  logic m0_rx;
  logic [3:0] rx_sub;
  logic [3:0] rx_bits;
  logic [8:0] rx_data;
  logic next_txd;

  logic access;
  logic wr;
  logic mapped;
  spu_mode_t mode;
  logic eleven;
  logic doubler;
  logic [3:0] frame_bits;
  logic [3:0] m0_div;
  logic tx_tick;
  logic rx_tick;
  logic buf_write;
  logic ctrl_write;
  logic tx_fin;
  logic m0_rx_fin;
  logic rx_fin;
  logic rx_accept;
  logic rx_set;
  logic tx_set;

  // Variable-rate 16x tick: timer B runs undivided, timer A halves unless doubled
  function automatic logic var_tick(input logic use_b, input logic ovf_a, input logic ovf_b,
                                    input logic dbl, input logic phase);
    var_tick = use_b ? ovf_b : (ovf_a & (dbl | phase));
  endfunction

  assign access = psel & penable;
  assign wr = access & pwrite;
  assign mode = spu_mode_t'(serial_control[BIT_MODE_HI:BIT_MODE_LO]);
  assign eleven = serial_control[BIT_MODE_HI];
  assign doubler = rate_config[BIT_RATE_DOUBLER];
  assign frame_bits = eleven ? BITS_ELEVEN : BITS_TEN; // [R02] [R03] [R04]
  assign m0_div = doubler ? M0_FAST : M0_SLOW; // [R15]
  assign buf_write = wr & (paddr == ADDR_BUF);
  assign ctrl_write = wr & (paddr == ADDR_CTRL);
  assign mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_BUF) | (paddr == ADDR_RATE)
    | (paddr == ADDR_IRQ_STATUS) | (paddr == ADDR_IRQ_MASK);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // Fixed mode uses the system-clock prescaler, timer modes the overflows
  assign tx_tick = (mode == MODE_FIX) ? fix_tick // [R16]
    : var_tick(rate_config[BIT_TX_TIMER_B], timer_a_ovf, timer_b_ovf, doubler, ta_phase); // [R17]
  assign rx_tick = (mode == MODE_FIX) ? fix_tick
    : var_tick(rate_config[BIT_RX_TIMER_B], timer_a_ovf, timer_b_ovf, doubler, ta_phase); // [R17]

  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL: prdata = {24'h00_0000, serial_control};
      ADDR_BUF: prdata = {24'h00_0000, rx_latch}; // [R14]
      ADDR_RATE: prdata = {29'h0000_0000, rate_config};
      ADDR_IRQ_STATUS: prdata = {30'h0000_0000, irq_status};
      ADDR_IRQ_MASK: prdata = {30'h0000_0000, irq_mask};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // Pin synchroniser; the second stage and the third stage that delays it feed logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      rxd_prev <= 1'b1;
    end
    else
    begin
      rxd_meta <= rxd_in;
      rxd_sync <= rxd_meta;
      rxd_prev <= rxd_sync;
    end
  end

  // Rate generation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fix_cnt <= 4'h0;
      fix_tick <= 1'b0;
      ta_phase <= 1'b0;
    end
    else
    begin
      if (fix_cnt >= (doubler ? SUB_FAST : SUB_SLOW) - 4'h1) // [R16]
      begin
        fix_cnt <= 4'h0;
        fix_tick <= 1'b1;
      end
      else
      begin
        fix_cnt <= fix_cnt + 4'h1;
        fix_tick <= 1'b0;
      end
      if (timer_a_ovf)
        ta_phase <= ~ta_phase;
    end
  end

  // Transmit engine; also runs shift-mode reception since it owns the clock
  assign tx_fin = ((tx_state == TX_ASYNC) && tx_tick && (tx_sub == SUB_LAST) && (tx_bits == frame_bits - 4'h1))
    || ((tx_state == TX_SYNC) && !m0_rx && (m0_cnt == m0_div - 4'h1) && (tx_bits == BITS_SHIFT - 4'h1));
  assign m0_rx_fin = (tx_state == TX_SYNC) && m0_rx && (m0_cnt == m0_div - 4'h1) && (tx_bits == BITS_SHIFT - 4'h1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= TX_IDLE;
      tx_shift <= 11'h7ff;
      tx_sub <= 4'h0;
      tx_bits <= 4'h0;
      m0_cnt <= 4'h0;
      m0_rx <= 1'b0;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          tx_sub <= 4'h0;
          tx_bits <= 4'h0;
          m0_cnt <= 4'h0;
          if (buf_write && mode == MODE_SHIFT) // [R14] [R01]
          begin
            tx_state <= TX_SYNC;
            m0_rx <= 1'b0;
            tx_shift <= {3'h7, pwdata[7:0]};
          end
          else if (buf_write) // [R14]
          begin
            tx_state <= TX_ASYNC;
            // Ten-bit frames put the stop bit where the ninth would go
            tx_shift <= {1'b1, eleven ? serial_control[BIT_TX_NINTH] : 1'b1, pwdata[7:0], 1'b0}; // [R12] [R02]
          end
          else if (mode == MODE_SHIFT && serial_control[BIT_RX_ENABLE] && !serial_control[BIT_RX_DONE]) // [R08]
          begin
            tx_state <= TX_SYNC;
            m0_rx <= 1'b1;
          end
        end
        TX_ASYNC:
        begin
          if (tx_tick)
          begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == SUB_LAST)
            begin
              tx_shift <= {1'b1, tx_shift[10:1]};
              tx_bits <= tx_bits + 4'h1;
              if (tx_fin)
                tx_state <= TX_IDLE;
            end
          end
        end
        TX_SYNC:
        begin
          if (m0_cnt == m0_div - 4'h1)
          begin
            m0_cnt <= 4'h0;
            tx_bits <= tx_bits + 4'h1;
            if (!m0_rx)
              tx_shift <= {1'b1, tx_shift[10:1]}; // [R01]
            if (tx_fin || m0_rx_fin)
              tx_state <= TX_IDLE;
          end
          else
          begin
            m0_cnt <= m0_cnt + 4'h1;
            // Sample on the rising clock edge, LSB arrives first
            if (m0_rx && m0_cnt == (m0_div >> 1))
              tx_shift[7:0] <= {rxd_sync, tx_shift[7:1]}; // [R01]
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  always_comb
  begin
    next_txd = 1'b1;
    if (tx_state == TX_SYNC)
      next_txd = (m0_cnt >= (m0_div >> 1)); // [R01] [R15]
    else if (tx_state == TX_ASYNC)
      next_txd = tx_shift[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
    end
    else
    begin
      txd <= next_txd;
      rxd_out <= tx_shift[0];
      rxd_oe <= (tx_state == TX_SYNC) && !m0_rx; // [R01]
    end
  end

  // Asynchronous receiver, disabled in shift mode
  assign rx_fin = (rx_state == RX_BUSY) && rx_tick && (rx_sub == SUB_MID) && (rx_bits == frame_bits - 4'h1);
  assign rx_accept = rx_fin && !(eleven && serial_control[BIT_MP_FILTER] && !rx_data[8]); // [R05] [R06] [R07]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state <= RX_IDLE;
      rx_sub <= 4'h0;
      rx_bits <= 4'h0;
      rx_data <= 9'h000;
    end
    else
    begin
      case (rx_state)
        RX_IDLE:
        begin
          rx_sub <= 4'h0;
          rx_bits <= 4'h0;
          if (mode != MODE_SHIFT && serial_control[BIT_RX_ENABLE] && rxd_prev && !rxd_sync) // [R08]
            rx_state <= RX_BUSY;
        end
        RX_BUSY:
        begin
          if (rx_tick)
          begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == SUB_MID)
            begin
              rx_bits <= rx_bits + 4'h1;
              // A start bit that is high again was a glitch
              if ((rx_bits == 4'h0 && rxd_sync) || rx_fin)
                rx_state <= RX_IDLE;
              else if (rx_bits != 4'h0)
                rx_data <= {rxd_sync, rx_data[8:1]};
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  assign rx_set = rx_accept || m0_rx_fin;
  assign tx_set = tx_fin;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_latch <= 8'h00;
    else if (m0_rx_fin)
      rx_latch <= tx_shift[7:0]; // [R01]
    else if (rx_accept)
      rx_latch <= eleven ? rx_data[7:0] : rx_data[8:1];
  end

  // Control register; hardware setting of a flag wins over a clearing write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      serial_control <= CTRL_RESET;
    else
    begin
      if (ctrl_write)
        serial_control[7:2] <= pwdata[7:2];
      if (rx_accept && eleven)
        serial_control[BIT_RX_NINTH] <= rx_data[8]; // [R09]
      serial_control[BIT_TX_DONE] <= tx_set | (serial_control[BIT_TX_DONE] & ~(ctrl_write & ~pwdata[BIT_TX_DONE])); // [R10] [R13]
      serial_control[BIT_RX_DONE] <= rx_set | (serial_control[BIT_RX_DONE] & ~(ctrl_write & ~pwdata[BIT_RX_DONE])); // [R11] [R13]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rate_config <= RATE_RESET;
      irq_mask <= IRQ_RESET;
    end
    else if (wr && paddr == ADDR_RATE)
      rate_config <= pwdata[2:0];
    else if (wr && paddr == ADDR_IRQ_MASK)
      irq_mask <= pwdata[1:0];
  end

  // Sticky event bits, write one to clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= IRQ_RESET;
    else
    begin
      irq_status[IRQ_RX] <= rx_set | (irq_status[IRQ_RX] & ~(wr && paddr == ADDR_IRQ_STATUS && pwdata[IRQ_RX]));
      irq_status[IRQ_TX] <= tx_set | (irq_status[IRQ_TX] & ~(wr && paddr == ADDR_IRQ_STATUS && pwdata[IRQ_TX]));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  AST_M0_OE: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
    rxd_oe |-> $past(tx_state) == TX_SYNC && !$past(m0_rx))
    else $error("data pin driven outside shift transmit");

  AST_M0_SLOW: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    $fell(txd) && tx_state == TX_SYNC && !doubler |-> !txd [*6] ##1 txd)
    else $error("shift clock low phase not six cycles");

  AST_M0_FAST: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    $fell(txd) && tx_state == TX_SYNC && doubler |-> !txd [*2] ##1 txd)
    else $error("shift clock low phase not two cycles");

  AST_FIX_RATE: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
    fix_tick && !doubler ##1 !doubler [*4]
    |-> fix_tick && !$past(fix_tick) && !$past(fix_tick, 2) && !$past(fix_tick, 3))
    else $error("fixed rate tick spacing wrong");

  AST_TX_START: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    buf_write && tx_state == TX_IDLE && mode != MODE_SHIFT |=> tx_state == TX_ASYNC && tx_shift[0] == 1'b0)
    else $error("buffer write did not start a frame");

  AST_TX_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    tx_fin |=> serial_control[BIT_TX_DONE] && irq_status[IRQ_TX])
    else $error("transmit flag not set at frame end");

  AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    serial_control[BIT_RX_DONE] && !ctrl_write |=> serial_control[BIT_RX_DONE])
    else $error("receive flag dropped without a write");

  AST_REN: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    rx_state == RX_IDLE && !serial_control[BIT_RX_ENABLE] |=> rx_state == RX_IDLE)
    else $error("reception began while disabled");

  AST_MP_FILTER: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
    rx_fin && eleven && serial_control[BIT_MP_FILTER] && !rx_data[8] && !serial_control[BIT_RX_DONE]
    && !ctrl_write |=> !serial_control[BIT_RX_DONE])
    else $error("filtered frame raised receive flag");

  AST_RX_NINTH: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
    rx_accept && eleven |=> serial_control[BIT_RX_NINTH] == $past(rx_data[8]))
    else $error("ninth bit not captured");

  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    rx_set && irq_mask[IRQ_RX] && !wr |-> ##2 irq)
    else $error("unmasked event did not raise interrupt");
endmodule

// ===== spu_remote_node.sv
// Remote serial node model facing the port's pins
`timescale 1ns/10ps
module spu_remote_node
(
  input wire logic pclk,
  input wire logic txd,
  input wire logic rxd_out,
  output logic rxd_line
);
  int bit_clks = 64;
  initial rxd_line = 1'b1;
  // Start, data LSB first, optional ninth, stop; line is left driven high after the stop bit
  task automatic send(input logic [8:0] d, input bit eleven);
    logic [10:0] f;
    f = eleven ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    for (int i = 0; i < (eleven ? 11 : 10); i++)
    begin
      rxd_line <= f[i];
      repeat (bit_clks) @(posedge pclk);
    end
  endtask
  // Samples mid-bit, so a wrong bit period corrupts the data seen
  task automatic recv(output logic [9:0] d, input bit eleven);
    d = '0;
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge pclk);
    for (int i = 0; i < (eleven ? 10 : 9); i++)
    begin
      repeat (bit_clks) @(posedge pclk);
      d[i] = txd;
    end
  endtask
  // Shift mode receive: new bit after each falling clock edge, LSB first
  task automatic shift_send(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge txd);
      rxd_line <= d[i];
    end
    @(posedge txd);
    rxd_line <= 1'b1;
  endtask
  // Shift mode: data taken at each rising edge of the shift clock
  task automatic shift_cap(output logic [7:0] d, output time per);
    time t0;
    t0 = 0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge txd);
      d[i] = rxd_out;
      if (i == 1)
        per = $time - t0;
      t0 = $time;
    end
  endtask
endmodule

// ===== testbench.sv
// Self-checking testbench of the serial port
`timescale 1ns/10ps
module testbench;
  import spu_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h57;
  logic pready, pslverr, timer_a_ovf = 0, timer_b_ovf = 0, rxd_line, rxd_out, rxd_oe, txd, irq;
  wire rxd_in = rxd_oe ? rxd_out : rxd_line;
  int fails = 0, n_compared = 0;
  always #20 pclk = ~pclk;
  // Timer pulses one clock wide, every second clock
  always @(posedge pclk)
  begin
    timer_a_ovf <= ~timer_a_ovf;
    timer_b_ovf <= ~timer_b_ovf;
  end
  spu_serial_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_a_ovf(timer_a_ovf), .timer_b_ovf(timer_b_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd), .irq(irq));
  spu_remote_node i_node (.pclk(pclk), .txd(txd), .rxd_out(rxd_out), .rxd_line(rxd_line));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] frame_of(logic [7:0] d, logic ninth, bit eleven);
    return eleven ? {22'h0, 1'b1, ninth, d} : {22'h0, 2'b01, d};
  endfunction
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Request held until pready is seen high; the idle edge after it avoids double drives
  task automatic apb(logic is_wr, logic [11:0] a, logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    if (n >= 100)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdchk(string name, logic [11:0] a, logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, '0, r, e);
    chk(name, exp, r);
  endtask
  task automatic stop_test();
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge pclk);
    fails++;
    stop_test();
  end
  initial
  begin
    logic [31:0] r, d, c;
    logic e;
    logic [9:0] f;
    logic [7:0] sd;
    time per;
    logic [1:0] md;
    logic [2:0] rt;
    bit el, filt;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("ctrl", ADDR_CTRL, 32'h0);
    rdchk("buffer", ADDR_BUF, 32'h0);
    rdchk("rate", ADDR_RATE, 32'h0);
    rdchk("irq_status", ADDR_IRQ_STATUS, 32'h0);
    apb(1'b0, 12'h004, '0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    wr(ADDR_CTRL, 32'hff);
    rdchk("ctrl_flags_kept", ADDR_CTRL, 32'hfc);
    wr(ADDR_CTRL, 32'h80);
    i_node.send(9'h1a5, 1'b1);
    repeat (4) @(posedge pclk);
    rdchk("ctrl_rx_off", ADDR_CTRL, 32'h80);
    // Modes 10 slow and fast, 11 on timer B, 01 on timer A; filter alternates
    for (int k = 0; k < 4; k++)
    begin
      md = (k == 3) ? 2'b01 : ((k == 2) ? 2'b11 : 2'b10);
      rt = (k == 1) ? 3'h1 : ((k == 2) ? 3'h6 : 3'h0);
      el = (k != 3);
      filt = k[0];
      i_node.bit_clks = (k == 1 || k == 2) ? 32 : 64;
      d = rnd();
      c = {24'h0, md, filt, 1'b1, d[8], 3'b000};
      wr(ADDR_RATE, {29'h0, rt});
      wr(ADDR_IRQ_MASK, (k == 0) ? 32'h0 : 32'h3);
      wr(ADDR_CTRL, c);
      wr(ADDR_BUF, {24'h0, d[7:0]});
      i_node.recv(f, el);
      chk("tx_frame", frame_of(d[7:0], d[8], el), {22'h0, f});
      repeat (i_node.bit_clks / 2 + 4) @(posedge pclk);
      rdchk("tx_flag", ADDR_CTRL, c | 32'h2);
      rdchk("irq_tx", ADDR_IRQ_STATUS, 32'h2);
      chk("irq_mask", {31'h0, k != 0}, {31'h0, irq});
      if (k == 0)
      begin
        wr(ADDR_IRQ_MASK, 32'h3);
        // The level output is registered, one clock after the mask
        @(posedge pclk);
        chk("irq_unmask", 32'h1, {31'h0, irq});
      end
      wr(ADDR_IRQ_STATUS, 32'h3);
      wr(ADDR_CTRL, c);
      chk("irq_clear", 32'h0, {31'h0, irq});
      i_node.send({1'b0, d[15:8]}, el);
      repeat (4) @(posedge pclk);
      rdchk("rx_filtered", ADDR_CTRL, c | {31'h0, !filt || !el});
      wr(ADDR_IRQ_STATUS, 32'h3);
      wr(ADDR_CTRL, c);
      i_node.send({1'b1, d[23:16]}, el);
      repeat (4) @(posedge pclk);
      rdchk("rx_flag", ADDR_CTRL, c | {29'h0, el, 2'b01});
      rdchk("rx_latch", ADDR_BUF, {24'h0, d[23:16]});
      chk("irq_rx", 32'h1, {31'h0, irq});
      wr(ADDR_IRQ_STATUS, 32'h3);
    end
    // Shift mode at both rates
    for (int k = 0; k < 2; k++)
    begin
      d = rnd();
      wr(ADDR_RATE, 32'(k));
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_BUF, {24'h0, d[7:0]});
      i_node.shift_cap(sd, per);
      chk("shift_data", {24'h0, d[7:0]}, {24'h0, sd});
      chk("shift_period", 32'((k ? 4 : 12) * 40), 32'(per));
      repeat (16) @(posedge pclk);
      rdchk("shift_tx_flag", ADDR_CTRL, 32'h2);
    end
    // Shift mode reception starts by itself once enabled
    wr(ADDR_RATE, 32'h0);
    wr(ADDR_CTRL, 32'h10);
    i_node.shift_send(d[15:8]);
    repeat (16) @(posedge pclk);
    rdchk("shift_rx_flag", ADDR_CTRL, 32'h11);
    rdchk("shift_rx_latch", ADDR_BUF, {24'h0, d[15:8]});
    stop_test();
  end
endmodule
